/* File: logic/rpv_pkg.sv */
// Constants and types shared by both ends of the palette video front end.
// Assumes one 100 MHz clock and an active-low asynchronous reset on all registers but the palette memories.
package rpv_pkg;
    localparam int CODE_W = 4;
    localparam int INDEX_W = 5;
    localparam int DEPTH = 32;
    localparam logic [CODE_W-1:0] BLACK_CODE = 4'h0;
    localparam logic [CODE_W-1:0] ZERO_CODE = 4'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 48;
    localparam int WRITE_PULSE_NS = 25;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LVL_DATA,
        LVL_BLACK,
        LVL_BLANK,
        LVL_SYNC
    } rpv_level_type;
endpackage

/* File: logic/rpv_if.sv */
// Pins between the graphics controller and the palette converter front end.
// All signals are plain levels sampled on CLK of both ends.
`timescale 1ns/1ps
interface rpv_if;
    import rpv_pkg::*;
    logic [CODE_W-1:0] red_entry_data;
    logic [CODE_W-1:0] green_entry_data;
    logic [CODE_W-1:0] blue_entry_data;
    logic [INDEX_W-1:0] palette_index;
    logic red_select_n;
    logic green_select_n;
    logic blue_select_n;
    logic read_write;
    logic blanking;
    logic sync;
    logic strobe;

    modport dev (
        input red_entry_data, green_entry_data, blue_entry_data,
        input palette_index, red_select_n, green_select_n, blue_select_n,
        input read_write, blanking, sync, strobe
    );
    modport ctl (
        output red_entry_data, green_entry_data, blue_entry_data,
        output palette_index, red_select_n, green_select_n, blue_select_n,
        output read_write, blanking, sync, strobe
    );
endinterface

/* File: logic/rpv_device.sv */
// Device end: three palette memories and the converter input registers.
// Assumes link pins are synchronous to CLK; strobe is sampled, not a clock.
`timescale 1ns/1ps
module rpv_device
    import rpv_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link from controller
    rpv_if.dev LINK,
    // Converter register contents and level selectors
    output logic [CODE_W-1:0] RED_CODE,
    output logic [CODE_W-1:0] GREEN_CODE,
    output logic [CODE_W-1:0] BLUE_CODE,
    output rpv_level_type RED_LEVEL,
    output rpv_level_type GREEN_LEVEL,
    output rpv_level_type BLUE_LEVEL
);

    // Palette storage has no reset: entries are unknown until written
    logic [CODE_W-1:0] mem_r [DEPTH];
    logic [CODE_W-1:0] mem_g [DEPTH];
    logic [CODE_W-1:0] mem_b [DEPTH];

    // Strobe history and its decoded falling edge
    logic strobe_q;
    logic fall;

    // Write enables, one per channel
    logic wr_r;
    logic wr_g;
    logic wr_b;

    // Raw memory words at the current index, before the select gate
    logic [CODE_W-1:0] word_r;
    logic [CODE_W-1:0] word_g;
    logic [CODE_W-1:0] word_b;

    // Memory words after the select gate
    logic [CODE_W-1:0] rd_r;
    logic [CODE_W-1:0] rd_g;
    logic [CODE_W-1:0] rd_b;

    // Values the converter registers take at the next strobe fall
    logic [CODE_W-1:0] red_code_d;
    logic [CODE_W-1:0] green_code_d;
    logic [CODE_W-1:0] blue_code_d;
    rpv_level_type red_level_d;
    rpv_level_type green_level_d;
    rpv_level_type blue_level_d;

    // A fall needs a high sample then a low one; a held low is no edge
    function automatic logic fell(input logic prev, input logic now);
        return prev && !now;
    endfunction

    // Write enable per channel: selected and read_write high
    function automatic logic wr_en(input logic sel_n, input logic write);
        return !sel_n && write;
    endfunction

    // Deselected memories present zero
    function automatic logic [CODE_W-1:0] rd_val(input logic sel_n,
            input logic [CODE_W-1:0] word);
        return sel_n ? ZERO_CODE : word;
    endfunction

    // Level per channel; a later test overrides an earlier one
    function automatic rpv_level_type lvl(input logic blank,
            input logic sync_on, input logic write, input logic is_green);
        rpv_level_type level;
        level = LVL_DATA;
        if (write) begin
            level = LVL_BLACK;
        end
        // Blanking outranks a write: a write while blanked shows blank
        if (blank) begin
            level = LVL_BLANK;
        end
        if (blank && sync_on && is_green) begin
            level = LVL_SYNC;
        end
        return level;
    endfunction

    // Only the data level shows a memory word; all else is code 0
    function automatic logic [CODE_W-1:0] code_for(
            input rpv_level_type level, input logic [CODE_W-1:0] word);
        case (level)
            LVL_DATA: begin
                return word;
            end
            default: begin
                return BLACK_CODE;
            end
        endcase
    endfunction

    assign fall = fell(strobe_q, LINK.strobe);
    assign wr_r = wr_en(LINK.red_select_n, LINK.read_write);
    assign wr_g = wr_en(LINK.green_select_n, LINK.read_write);
    assign wr_b = wr_en(LINK.blue_select_n, LINK.read_write);
    assign word_r = mem_r[LINK.palette_index];
    assign word_g = mem_g[LINK.palette_index];
    assign word_b = mem_b[LINK.palette_index];
    assign rd_r = rd_val(LINK.red_select_n, word_r);
    assign rd_g = rd_val(LINK.green_select_n, word_g);
    assign rd_b = rd_val(LINK.blue_select_n, word_b);

    // Red next values; a deselected red reads zero, so it goes black
    always_comb begin
        red_level_d = lvl(LINK.blanking, LINK.sync, LINK.read_write, 1'b0);
        red_code_d = code_for(red_level_d, rd_r);
    end

    // Green next values; green alone can show the sync level
    always_comb begin
        green_level_d = lvl(LINK.blanking, LINK.sync, LINK.read_write, 1'b1);
        green_code_d = code_for(green_level_d, rd_g);
    end

    // Blue next values
    always_comb begin
        blue_level_d = lvl(LINK.blanking, LINK.sync, LINK.read_write, 1'b0);
        blue_code_d = code_for(blue_level_d, rd_b);
    end

    // History starts at the idle level, so releasing reset makes no edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= LINK.strobe;
        end
    end

    // Writes go in whatever the blanking state
    // One process per channel so each write enable stands alone
    always_ff @(posedge CLK) begin
        if (wr_r) begin
            mem_r[LINK.palette_index] <= LINK.red_entry_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_g) begin
            mem_g[LINK.palette_index] <= LINK.green_entry_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_b) begin
            mem_b[LINK.palette_index] <= LINK.blue_entry_data;
        end
    end

    // Registers change only on a strobe fall, otherwise they hold
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RED_CODE <= BLACK_CODE;
        end else if (fall) begin
            RED_CODE <= red_code_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            GREEN_CODE <= BLACK_CODE;
        end else if (fall) begin
            GREEN_CODE <= green_code_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BLUE_CODE <= BLACK_CODE;
        end else if (fall) begin
            BLUE_CODE <= blue_code_d;
        end
    end

    // Selectors follow the same strobe edge as the codes
    // A deselected channel keeps the data level; its code is already 0
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RED_LEVEL <= LVL_BLACK;
        end else if (fall) begin
            RED_LEVEL <= red_level_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            GREEN_LEVEL <= LVL_BLACK;
        end else if (fall) begin
            GREEN_LEVEL <= green_level_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BLUE_LEVEL <= LVL_BLACK;
        end else if (fall) begin
            BLUE_LEVEL <= blue_level_d;
        end
    end
endmodule

/* File: logic/rpv_controller.sv */
// Controller end: palette writes, pixel display strobes and blanking.
// Assumes the user side holds a request until it is accepted by ready.
`timescale 1ns/1ps
module rpv_controller
    import rpv_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link to device
    rpv_if.ctl LINK,
    // Palette write request
    input wire logic WR_REQ,
    input wire logic [1:0] WR_CHAN,
    input wire logic [INDEX_W-1:0] WR_INDEX,
    input wire logic [CODE_W-1:0] WR_CODE,
    // Pixel request
    input wire logic PIX_REQ,
    input wire logic [INDEX_W-1:0] PIX_INDEX,
    input wire logic PIX_BLANK,
    input wire logic PIX_SYNC,
    // Status
    output logic READY
);
    typedef enum {
        ST_IDLE,
        ST_WSEL,
        ST_WPULSE,
        ST_WEND,
        ST_WAIT,
        ST_STROBE
    } rpv_state_type;

    rpv_state_type state_q;
    logic [3:0] cnt_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            READY <= 1'b0;
            LINK.red_entry_data <= BLACK_CODE;
            LINK.green_entry_data <= BLACK_CODE;
            LINK.blue_entry_data <= BLACK_CODE;
            LINK.palette_index <= 5'h00;
            LINK.red_select_n <= 1'b1;
            LINK.green_select_n <= 1'b1;
            LINK.blue_select_n <= 1'b1;
            LINK.read_write <= 1'b0;
            LINK.blanking <= 1'b0;
            LINK.sync <= 1'b0;
            LINK.strobe <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    LINK.strobe <= 1'b1;
                    READY <= 1'b1;
                    if (WR_REQ) begin
                        // The one channel WR_CHAN names is selected for a write; WR_CHAN 3 selects none
                        READY <= 1'b0;
                        LINK.palette_index <= WR_INDEX;
                        LINK.red_entry_data <= WR_CODE;
                        LINK.green_entry_data <= WR_CODE;
                        LINK.blue_entry_data <= WR_CODE;
                        LINK.red_select_n <= (WR_CHAN != 2'd0);
                        LINK.green_select_n <= (WR_CHAN != 2'd1);
                        LINK.blue_select_n <= (WR_CHAN != 2'd2);
                        state_q <= ST_WSEL;
                    end else if (PIX_REQ) begin
                        // All selects low for display; sync only with blank
                        READY <= 1'b0;
                        LINK.palette_index <= PIX_INDEX;
                        LINK.red_select_n <= 1'b0;
                        LINK.green_select_n <= 1'b0;
                        LINK.blue_select_n <= 1'b0;
                        LINK.blanking <= PIX_BLANK;
                        LINK.sync <= PIX_BLANK && PIX_SYNC;
                        cnt_q <= 4'(ACCESS_CYC);
                        state_q <= ST_WAIT;
                    end
                end
                ST_WSEL: begin
                    LINK.read_write <= 1'b1;
                    cnt_q <= 4'(WRITE_CYC);
                    state_q <= ST_WPULSE;
                end
                ST_WPULSE: begin
                    if (cnt_q <= 4'h1) begin
                        LINK.read_write <= 1'b0;
                        state_q <= ST_WEND;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_WEND: begin
                    LINK.red_select_n <= 1'b1;
                    LINK.green_select_n <= 1'b1;
                    LINK.blue_select_n <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_WAIT: begin
                    // Access delay before the latching edge
                    if (cnt_q <= 4'h1) begin
                        LINK.strobe <= 1'b0;
                        state_q <= ST_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_STROBE: begin
                    LINK.strobe <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verif/rpv_props.sv */
// Checker for the palette front end link pins and converter outputs.
// Instantiated beside the link interface; one clock, async low reset.
`timescale 1ns/1ps
module rpv_props
    import rpv_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link pins
    input wire logic [INDEX_W-1:0] palette_index,
    input wire logic red_select_n,
    input wire logic green_select_n,
    input wire logic blue_select_n,
    input wire logic read_write,
    input wire logic blanking,
    input wire logic sync,
    input wire logic strobe,
    // Converter outputs
    input wire logic [CODE_W-1:0] RED_CODE,
    input wire logic [CODE_W-1:0] GREEN_CODE,
    input wire logic [CODE_W-1:0] BLUE_CODE,
    input wire rpv_level_type RED_LEVEL,
    input wire rpv_level_type GREEN_LEVEL,
    input wire rpv_level_type BLUE_LEVEL
);
    logic [11:0] codes;
    assign codes = {RED_CODE, GREEN_CODE, BLUE_CODE};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence fall_read_s;
        $fell(strobe) && !read_write && !blanking;
    endsequence
    sequence wr_pulse_s;
        read_write [*3];
    endsequence
    blank_clear_a: assert property (
        $fell(strobe) && blanking && !sync |=> codes == 12'h000 &&
        RED_LEVEL == LVL_BLANK && GREEN_LEVEL == LVL_BLANK)
        else $error("blanking strobe did not clear");
    sync_green_a: assert property (
        $fell(strobe) && blanking && sync |=> codes == 12'h000 &&
        GREEN_LEVEL == LVL_SYNC && BLUE_LEVEL == LVL_BLANK)
        else $error("sync strobe gave wrong levels");
    write_black_a: assert property (
        $fell(strobe) && read_write && !blanking |=> codes == 12'h000 &&
        RED_LEVEL == LVL_BLACK && BLUE_LEVEL == LVL_BLACK)
        else $error("strobe in write mode not black");
    desel_black_a: assert property (
        fall_read_s ##0 red_select_n |=> RED_CODE == BLACK_CODE)
        else $error("deselected channel not black");
    read_level_a: assert property (
        fall_read_s ##0 !green_select_n |=> GREEN_LEVEL == LVL_DATA)
        else $error("read strobe level not data");
    hold_value_a: assert property (
        !$fell(strobe) |=> $stable(codes) && $stable(GREEN_LEVEL))
        else $error("outputs changed without strobe");
    access_wait_a: assert property (
        $fell(strobe) |-> $past(palette_index, 5) == palette_index)
        else $error("strobe too soon after index");
    write_pulse_a: assert property (
        $rose(read_write) |-> wr_pulse_s)
        else $error("write pulse too short");
    one_select_a: assert property (
        read_write |-> $countones({red_select_n, green_select_n,
        blue_select_n}) == 2)
        else $error("write not to exactly one channel");
    display_sel_a: assert property (
        $fell(strobe) |-> !red_select_n && !green_select_n &&
        !blue_select_n && !read_write)
        else $error("display strobe without all selects");
endmodule

/* File: verif/rgb_palette_video_dac_front_tb.sv */
// Bench joining controller and device through the link interface.
// Drives the controller user side and checks converter outputs.
`timescale 1ns/1ps
module rgb_palette_video_dac_front_tb;
    import rpv_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic WR_REQ = 1'b0;
    logic [1:0] WR_CHAN = 2'h0;
    logic [INDEX_W-1:0] WR_INDEX = 5'h00;
    logic [CODE_W-1:0] WR_CODE = 4'h0;
    logic PIX_REQ = 1'b0;
    logic [INDEX_W-1:0] PIX_INDEX = 5'h00;
    logic PIX_BLANK = 1'b0;
    logic PIX_SYNC = 1'b0;
    logic READY;
    logic [CODE_W-1:0] RED_CODE, GREEN_CODE, BLUE_CODE;
    rpv_level_type RED_LEVEL, GREEN_LEVEL, BLUE_LEVEL;
    logic [11:0] codes;
    logic [5:0] lvls;
    logic [CODE_W-1:0] shadow [3][DEPTH];
    logic [INDEX_W-1:0] picks [4] = '{5'h00, 5'h1f, 5'h0a, 5'h15};
    int bad_count = 0;
    int compares = 0;
    assign codes = {RED_CODE, GREEN_CODE, BLUE_CODE};
    assign lvls = {RED_LEVEL, GREEN_LEVEL, BLUE_LEVEL};
    rpv_if link();
    rpv_controller i_rpv_controller (.CLK(CLK), .RST_N(RST_N), .LINK(link),
        .WR_REQ(WR_REQ), .WR_CHAN(WR_CHAN), .WR_INDEX(WR_INDEX),
        .WR_CODE(WR_CODE), .PIX_REQ(PIX_REQ), .PIX_INDEX(PIX_INDEX),
        .PIX_BLANK(PIX_BLANK), .PIX_SYNC(PIX_SYNC), .READY(READY));
    rpv_device i_rpv_device (.CLK(CLK), .RST_N(RST_N), .LINK(link),
        .RED_CODE(RED_CODE), .GREEN_CODE(GREEN_CODE), .BLUE_CODE(BLUE_CODE),
        .RED_LEVEL(RED_LEVEL), .GREEN_LEVEL(GREEN_LEVEL),
        .BLUE_LEVEL(BLUE_LEVEL));
    rpv_props i_rpv_props (.CLK(CLK), .RST_N(RST_N),
        .palette_index(link.palette_index), .red_select_n(link.red_select_n),
        .green_select_n(link.green_select_n),
        .blue_select_n(link.blue_select_n), .read_write(link.read_write),
        .blanking(link.blanking), .sync(link.sync), .strobe(link.strobe),
        .RED_CODE(RED_CODE), .GREEN_CODE(GREEN_CODE), .BLUE_CODE(BLUE_CODE),
        .RED_LEVEL(RED_LEVEL), .GREEN_LEVEL(GREEN_LEVEL),
        .BLUE_LEVEL(BLUE_LEVEL));
    always #5 CLK = ~CLK;
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge CLK);
        while (READY !== 1'b1 && n < 200) begin
            @(negedge CLK);
            n++;
        end
        if (READY !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask
    // Request is held from one edge to the next, where READY takes it
    task automatic go(input logic w, input logic [1:0] ch,
            input logic [INDEX_W-1:0] idx, input logic [CODE_W-1:0] code,
            input logic b, input logic s);
        wait_ready();
        @(posedge CLK);
        WR_REQ <= w;
        PIX_REQ <= !w;
        WR_CHAN <= ch;
        WR_INDEX <= idx;
        WR_CODE <= code;
        PIX_INDEX <= idx;
        PIX_BLANK <= b;
        PIX_SYNC <= s;
        @(posedge CLK);
        WR_REQ <= 1'b0;
        PIX_REQ <= 1'b0;
        wait_ready();
    endtask
    function automatic logic [11:0] ent(input logic [INDEX_W-1:0] i);
        return {shadow[0][i], shadow[1][i], shadow[2][i]};
    endfunction
    task automatic pix(input logic [INDEX_W-1:0] idx, input logic b,
            input logic s, input logic [11:0] ec, input logic [5:0] el);
        go(1'b0, 2'h0, idx, 4'h0, b, s);
        chk(codes, ec);
        chk({6'h00, lvls}, {6'h00, el});
    endtask
    task automatic final_report();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        // Indices 0, 31, 10 and 21, every channel
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 3; c++) begin
                shadow[c][picks[i]] = 4'(15 - i * 4 - c);
                go(1'b1, 2'(c), picks[i], shadow[c][picks[i]], 1'b0, 1'b0);
            end
        end
        for (int i = 0; i < 4; i++) begin
            pix(picks[i], 1'b0, 1'b0, ent(picks[i]), 6'h00);
        end
        go(1'b1, 2'h0, picks[3], 4'h0, 1'b0, 1'b0);
        chk(codes, ent(picks[3]));
        shadow[0][picks[3]] = 4'h0;
        pix(picks[3], 1'b0, 1'b0, ent(picks[3]), 6'h00);
        pix(picks[1], 1'b1, 1'b0, 12'h000, {3{LVL_BLANK}});
        pix(picks[1], 1'b1, 1'b1, 12'h000,
            {LVL_BLANK, LVL_SYNC, LVL_BLANK});
        pix(picks[1], 1'b0, 1'b0, ent(picks[1]), 6'h00);
        final_report();
    end
endmodule
